// ==== quad_output_read_path.sv ====
// serial flash quad-output read sequencer, device side
// assumes array data arrives on mem_data one core cycle after mem_addr
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] address bits are sampled on each rising serial clock edge
// [R2] data leaves four bits per falling clock edge on four lines
// [R3] any byte address may start a read, no alignment
// [R4] address counter steps by one after every byte sent
// [R5] counter past the top address wraps to zero and continues
// [R6] three-byte address by default; wide mode or extended bit reach more
// [R7] host drops select, sends command then address on line zero
// [R8] dummy clocks sit between address and data; nothing driven then
// [R9] after this command data is four wide; command, address single line
// [R10] select rising during data stops output and ends the read
// [R11] read command is ignored while program, erase or status write busy
// [R12] dummy clock count comes from configuration bits six and seven
// [R13] wide mode adds eight address clocks; later phases shift along
// [R14] enter-wide command sets configuration bit five until cleared
// [R15] host releases all four lines before the first data clock
module quad_output_read_path
    import quad_output_read_cmd_pkg::*;
#(
    parameter int             ADDR_W   = 26,
    parameter logic [ADDR_W-1:0] MEM_LAST = {ADDR_W{1'b1}}
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               cs_n_pin,
    input  wire logic               sclk_pin,
    input  wire logic               io_line_0,
    output logic [3:0]              io_out,
    output logic [3:0]              io_oe,
    output logic [ADDR_W-1:0]       mem_addr,
    input  wire logic [7:0]         mem_data,
    input  wire logic               write_busy,
    input  wire logic [ADDR_W-25:0] extended_addr_bit,
    input  wire logic               cfg_wr_en,
    input  wire logic [7:0]         cfg_wr_data,
    output logic [7:0]              cfg_q,
    output logic                    wide_addr_flag,
    output logic                    read_active
);
    typedef struct packed
    {
        seq_state_type     st;
        logic [5:0]        cnt;
        logic [31:0]       sh;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic              nib;
        logic [3:0]        dout;
        logic              oe;
        logic [7:0]        cfg;
    } rd_state_type;

    rd_state_type q;
    rd_state_type d;
    logic [31:0]  shifted;
    pin_sync_if   sync ();

    pin_filter i_pin_filter
    (
        .core_clk (core_clk),
        .rst      (rst),
        .cs_n_pin (cs_n_pin),
        .sclk_pin (sclk_pin),
        .io0_pin  (io_line_0),
        .sync     (sync)
    );

    // dummy count from the two configuration bits
    function automatic logic [5:0] dummy_len(input logic [7:0] cfg);
        logic [1:0] code;
        code = {cfg[DUMMY_HI_POS], cfg[DUMMY_LO_POS]};
        case (code)
            2'h0:    dummy_len = DUMMY_CODE0;
            2'h1:    dummy_len = DUMMY_CODE1;
            2'h2:    dummy_len = DUMMY_CODE2;
            default: dummy_len = DUMMY_CODE3;
        endcase
    endfunction

    // address phase length follows the wide flag
    function automatic logic [5:0] addr_len(input logic [7:0] cfg);
        addr_len = cfg[WIDE_FLAG_POS] ? ADDR_BITS_WID : ADDR_BITS_NAR;
    endfunction

    // [R1] shift on rising edge
    assign shifted = {q.sh[30:0], sync.io0_lvl};

    always_comb
    begin
        d = q;
        if (cfg_wr_en)
            d.cfg = cfg_wr_data;
        // [R7] select low opens a frame
        case (q.st)
            ST_IDLE:
            begin
                if (!sync.cs_n_lvl)
                begin
                    d.st  = ST_CMD;
                    d.cnt = 6'h00;
                end
            end
            ST_CMD:
            begin
                if (sync.sclk_rise)
                begin
                    d.sh  = shifted;
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == CMD_BITS - 6'h01)
                    begin
                        d.cnt = 6'h00;
                        d.st  = ST_IGNORE;
                        // [R11] busy write rejects read
                        if (shifted[7:0] == QUAD_OUTPUT_READ_CMD
                            && !write_busy)
                            d.st = ST_ADDR;
                        // [R14] wide flag set and cleared
                        if (shifted[7:0] == ENTER_WIDE_ADDR_CMD)
                            d.cfg[WIDE_FLAG_POS] = 1'b1;
                        if (shifted[7:0] == EXIT_WIDE_ADDR_CMD)
                            d.cfg[WIDE_FLAG_POS] = 1'b0;
                    end
                end
            end
            ST_ADDR:
            begin
                if (sync.sclk_rise)
                begin
                    d.sh  = shifted;
                    d.cnt = q.cnt + 6'h01;
                    // [R13] length from wide flag
                    if (q.cnt == addr_len(q.cfg) - 6'h01)
                    begin
                        d.cnt = 6'h00;
                        d.st  = ST_DUMMY;
                        // [R6] narrow mode uses extended bits
                        // [R3] any start address taken as is
                        if (q.cfg[WIDE_FLAG_POS])
                            d.addr = shifted[ADDR_W-1:0];
                        else
                            d.addr = {extended_addr_bit, shifted[23:0]};
                    end
                end
            end
            ST_DUMMY:
            begin
                // [R8] [R12] count dummies, lines stay released
                if (sync.sclk_rise)
                begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == dummy_len(q.cfg) - 6'h01)
                    begin
                        d.st  = ST_DATA;
                        d.nib = 1'b0;
                    end
                end
            end
            ST_DATA:
            begin
                // [R2] [R9] nibble out per falling edge
                if (sync.sclk_fall)
                begin
                    d.oe  = 1'b1;
                    d.nib = ~q.nib;
                    if (!q.nib)
                    begin
                        d.dout = mem_data[7:4];
                        d.data = mem_data;
                    end
                    else
                    begin
                        d.dout = q.data[3:0];
                        // [R4] [R5] step and wrap
                        if (q.addr == MEM_LAST)
                            d.addr = '0;
                        else
                            d.addr = q.addr + 1'b1;
                    end
                end
            end
            ST_IGNORE:
            begin
                d.oe = 1'b0;
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
        // [R10] select high ends any frame
        if (sync.cs_n_lvl)
        begin
            d.st  = ST_IDLE;
            d.oe  = 1'b0;
            d.nib = 1'b0;
            d.cnt = 6'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q <= '{st: ST_IDLE, cnt: 6'h00, sh: 32'h0000_0000,
                   addr: '0, data: 8'h00, nib: 1'b0, dout: 4'h0,
                   oe: 1'b0, cfg: CFG_RESET};
        end
        else
        begin
            q <= d;
        end
    end

    // [R15] lines driven only in data phase
    assign io_oe          = {4{q.oe}};
    assign io_out         = q.dout;
    assign mem_addr       = q.addr;
    assign cfg_q          = q.cfg;
    assign wide_addr_flag = q.cfg[WIDE_FLAG_POS];
    assign read_active    = (q.st == ST_DATA);
endmodule
`default_nettype wire

// ==== quad_output_read_cmd_pkg.sv ====
// constants for the quad-output read path
// assumes a single 125 MHz core clock; link pins sampled by it
package quad_output_read_cmd_pkg;

    localparam logic [7:0] QUAD_OUTPUT_READ_CMD = 8'h6b;
    localparam logic [7:0] ENTER_WIDE_ADDR_CMD  = 8'ha5;
    localparam logic [7:0] EXIT_WIDE_ADDR_CMD   = 8'ha6;

    localparam logic [5:0] CMD_BITS      = 6'h08;
    localparam logic [5:0] ADDR_BITS_NAR = 6'h18;
    localparam logic [5:0] ADDR_BITS_WID = 6'h20;

    localparam logic [5:0] DUMMY_CODE0 = 6'h08;
    localparam logic [5:0] DUMMY_CODE1 = 6'h04;
    localparam logic [5:0] DUMMY_CODE2 = 6'h06;
    localparam logic [5:0] DUMMY_CODE3 = 6'h0a;

    localparam int         WIDE_FLAG_POS = 5;
    localparam int         DUMMY_LO_POS  = 6;
    localparam int         DUMMY_HI_POS  = 7;
    localparam logic [7:0] CFG_RESET     = 8'h00;

    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT   = 3;
    localparam int PIN_CS      = 0;
    localparam int PIN_SCLK    = 1;
    localparam int PIN_IO0     = 2;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'h0,
        ST_CMD    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_DUMMY  = 3'h2,
        ST_DATA   = 3'h6,
        ST_IGNORE = 3'h7
    } seq_state_type;

endpackage

// ==== pin_sync_if.sv ====
// carries filtered link levels and clock edges to the sequencer
// driven by pin_filter, read by the read path
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if;
    logic cs_n_lvl;
    logic io0_lvl;
    logic sclk_rise;
    logic sclk_fall;
    modport src (output cs_n_lvl, output io0_lvl, output sclk_rise,
                 output sclk_fall);
    modport dst (input cs_n_lvl, input io0_lvl, input sclk_rise,
                 input sclk_fall);
endinterface
`default_nettype wire

// ==== pin_filter.sv ====
// three-stage synchroniser and agreement filter for link pins
// assumes pins are asynchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module pin_filter
    import quad_output_read_cmd_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             cs_n_pin,
    input  wire logic             sclk_pin,
    input  wire logic             io0_pin,
    pin_sync_if.src               sync
);
    typedef struct packed
    {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] lvl;
        logic                 rise;
        logic                 fall;
    } filt_state_type;

    filt_state_type q;
    filt_state_type d;
    logic [PIN_COUNT-1:0] raw;

    assign raw[PIN_CS]   = cs_n_pin;
    assign raw[PIN_SCLK] = sclk_pin;
    assign raw[PIN_IO0]  = io0_pin;

    always_comb
    begin
        d      = q;
        d.s1   = raw;
        d.s2   = q.s1;
        d.s3   = q.s2;
        // first stage feeds only the second; filter looks at s2 and s3
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            if (q.s2[i] == q.s3[i])
                d.lvl[i] = q.s2[i];
        end
        d.rise = d.lvl[PIN_SCLK] & ~q.lvl[PIN_SCLK];
        d.fall = ~d.lvl[PIN_SCLK] & q.lvl[PIN_SCLK];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q <= '{s1: 3'h5, s2: 3'h5, s3: 3'h5, lvl: 3'h5,
                   rise: 1'b0, fall: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign sync.cs_n_lvl  = q.lvl[PIN_CS];
    assign sync.io0_lvl   = q.lvl[PIN_IO0];
    assign sync.sclk_rise = q.rise;
    assign sync.sclk_fall = q.fall;
endmodule
`default_nettype wire

// ==== quad_output_read_path_asserts.sv ====
// port assertions for the quad-output read path
// assumes bind into the design, single core clock domain
`timescale 1ns/10ps
`default_nettype none
module quad_output_read_path_asserts
#(
    parameter int                ADDR_W   = 26,
    parameter logic [ADDR_W-1:0] MEM_LAST = {ADDR_W{1'b1}}
)
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              cs_n_pin,
    input wire logic              sclk_pin,
    input wire logic [3:0]        io_out,
    input wire logic [3:0]        io_oe,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0]        mem_data,
    input wire logic              cfg_wr_en,
    input wire logic [7:0]        cfg_wr_data,
    input wire logic [7:0]        cfg_q,
    input wire logic              wide_addr_flag,
    input wire logic              read_active
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_oe_all_four:
        assert property (io_oe == 4'h0 || io_oe == 4'hf)
        else $error("partial output enable");
    // filter plus decode settle well inside eight cycles
    a_quiet_deselect:
        assert property (cs_n_pin [*8] |-> io_oe == 4'h0 && !read_active)
        else $error("output after deselect");
    a_oe_drop_late:
        assert property ($fell(io_oe[0]) |-> $past(cs_n_pin, 3))
        else $error("enable dropped with select low");
    a_addr_step:
        assert property (read_active && $past(read_active) &&
            $changed(mem_addr) |-> mem_addr == ($past(mem_addr) == MEM_LAST
            ? '0 : $past(mem_addr) + 1'b1)) else $error("address skipped");
    a_first_nibble:
        assert property ($rose(io_oe[0]) |-> io_out == mem_data[7:4])
        else $error("first nibble wrong");
    a_out_on_fall:
        assert property (io_oe[0] && $changed(io_out) |-> !sclk_pin)
        else $error("data moved with clock high");
    // flag may only move on a config load or inside a selected frame
    a_flag_source:
        assert property ($changed(wide_addr_flag) |->
            $past(cfg_wr_en) || !$past(cs_n_pin))
        else $error("wide flag moved outside command or write");
    a_oe_in_data:
        assert property (io_oe[0] |-> read_active)
        else $error("lines driven outside data phase");
    a_cfg_load:
        assert property (cfg_wr_en |=>
            {cfg_q[7:6], 6'h00} == ($past(cfg_wr_data) & 8'hc0))
        else $error("dummy bits not loaded");
    c_wrap: cover property (read_active && mem_addr == '0);
    c_wide: cover property ($rose(wide_addr_flag));
    c_stop: cover property ($fell(io_oe[0]));
endmodule
bind quad_output_read_path quad_output_read_path_asserts
    #(.ADDR_W(ADDR_W), .MEM_LAST(MEM_LAST)) i_quad_output_read_path_asserts
    (.core_clk, .rst, .cs_n_pin, .sclk_pin, .io_out, .io_oe, .mem_addr,
     .mem_data, .cfg_wr_en, .cfg_wr_data, .cfg_q, .wide_addr_flag,
     .read_active);
`default_nettype wire

// ==== flash_host_model.sv ====
// host side of the link: select, serial clock, line zero, nibble capture
// assumes 160 ns serial clock, idle low, stopped between frames
`timescale 1ns/10ps
`default_nettype none
module flash_host_model
(
    output var logic        cs_n_pin,
    output var logic        sclk_pin,
    output var logic        io_line_0,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [7:0] got [0:15];
    int         got_n;
    int         oe_seen;
    logic [3:0] smp;
    initial
    begin
        cs_n_pin  = 1'b1;
        sclk_pin  = 1'b0;
        io_line_0 = 1'b0;
    end
    // released line toggles, so a stale level never looks valid
    task automatic tick(input logic b);
        io_line_0 = b;
        #80 smp = io_oe === 4'hf ? io_out : 4'hx;
        oe_seen = oe_seen + (io_oe === 4'hf);
        sclk_pin = 1'b1;
        #80 sclk_pin = 1'b0;
    endtask
    // select, command, address, dummies, data nibbles
    task automatic frame(input logic [7:0] cmd, input logic [31:0] adr,
                         input int na, input int nd, input int nn);
        logic [3:0] hi;
        got_n    = 0;
        oe_seen  = 0;
        cs_n_pin = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--) tick(cmd[i]);
        for (int i = na - 1; i >= 0; i--) tick(adr[i]);
        for (int i = 0; i < nd; i++) tick(~io_line_0);
        for (int i = 0; i < nn; i++)
        begin
            tick(~io_line_0);
            got[got_n] = {hi, smp};
            got_n = got_n + i % 2;
            hi = smp;
        end
        #80 cs_n_pin = 1'b1;
        io_line_0 = ~io_line_0;
        #400;
    endtask
endmodule
`default_nettype wire

// ==== quad_output_read_path_bench.sv ====
// self-checking bench for the quad-output read path
// assumes host model on the pins and a behavioural array on mem ports
`timescale 1ns/10ps
`default_nettype none
module quad_output_read_path_bench;
    import quad_output_read_cmd_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        cs_n_pin;
    logic        sclk_pin;
    logic        io_line_0;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [25:0] mem_addr;
    logic [7:0]  mem_data;
    logic        write_busy;
    logic [1:0]  extended_addr_bit;
    logic        cfg_wr_en;
    logic [7:0]  cfg_wr_data;
    logic [7:0]  cfg_q;
    logic        wide_addr_flag;
    logic        read_active;
    int          err_total;
    int          compares;
    int          seed;
    quad_output_read_path i_quad_output_read_path
    (
        .core_clk, .rst, .cs_n_pin, .sclk_pin, .io_line_0, .io_out, .io_oe,
        .mem_addr, .mem_data, .write_busy, .extended_addr_bit, .cfg_wr_en,
        .cfg_wr_data, .cfg_q, .wide_addr_flag, .read_active
    );
    flash_host_model i_flash_host_model
    (
        .cs_n_pin, .sclk_pin, .io_line_0, .io_out, .io_oe
    );
    function automatic logic [7:0] mem_f(input logic [25:0] a);
        return a[7:0] ^ a[15:8] ^ {a[25:20], 2'h1};
    endfunction
    assign mem_data = mem_f(mem_addr);
    function automatic int dummies(input logic [1:0] c);
        return c == 2'h0 ? DUMMY_CODE0 : c == 2'h1 ? DUMMY_CODE1 :
               c == 2'h2 ? DUMMY_CODE2 : DUMMY_CODE3;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cfg_write(input logic [7:0] v);
        @(posedge core_clk) #1;
        cfg_wr_en   = 1'b1;
        cfg_wr_data = v;
        @(posedge core_clk) #1;
        cfg_wr_en = 1'b0;
    endtask
    task automatic read_chk(input logic [31:0] a, input int na,
                            input int nd, input int nb);
        logic [25:0] s;
        s = na == 24 ? {extended_addr_bit, a[23:0]} : a[25:0];
        i_flash_host_model.frame(QUAD_OUTPUT_READ_CMD, a, na, nd, 2 * nb);
        check(i_flash_host_model.oe_seen, 2 * nb);
        for (int k = 0; k < nb; k++)
            check(i_flash_host_model.got[k], mem_f(26'(s + k)));
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        err_total++;
        test_done;
    end
    initial
    begin
        seed = 32'h593ccc63;
        err_total = 0;
        compares = 0;
        rst = 1'b1;
        write_busy = 1'b0;
        extended_addr_bit = 2'h0;
        cfg_wr_en = 1'b0;
        cfg_wr_data = 8'h00;
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        check(cfg_q, CFG_RESET);
        check({io_oe, wide_addr_flag, read_active}, 6'h00);
        // every dummy code, ending on the default one
        for (int c = 3; c >= 0; c--)
        begin
            cfg_write({c[1:0], 6'h00});
            extended_addr_bit = 2'($random(seed));
            read_chk($random(seed), 24, dummies(c[1:0]), 3);
        end
        extended_addr_bit = 2'h3;
        read_chk(32'h00fffffe, 24, DUMMY_CODE0, 3);
        i_flash_host_model.frame(ENTER_WIDE_ADDR_CMD, 32'h0, 0, 0, 0);
        check({wide_addr_flag, cfg_q[WIDE_FLAG_POS]}, 2'h3);
        read_chk($random(seed), 32, DUMMY_CODE0, 2);
        i_flash_host_model.frame(EXIT_WIDE_ADDR_CMD, 32'h0, 0, 0, 0);
        check(wide_addr_flag, 1'b0);
        @(posedge core_clk) #1;
        write_busy = 1'b1;
        i_flash_host_model.frame(QUAD_OUTPUT_READ_CMD, 32'h0, 24, 8, 4);
        check(i_flash_host_model.oe_seen, 0);
        @(posedge core_clk) #1;
        write_busy = 1'b0;
        // select rises after three sampled nibbles, once the fourth nibble is already driven
        i_flash_host_model.frame(QUAD_OUTPUT_READ_CMD, 32'h100, 24, 8, 3);
        check({io_oe, read_active}, 5'h00);
        test_done;
    end
endmodule
`default_nettype wire
